// [rtl/pfcr_cfg.svh]
// Offsets, field positions, reset values and timing counts of the command block.
`ifndef PFCR_CFG_SVH
`define PFCR_CFG_SVH

// Byte offsets on the register bus.
`define PFCR_OFF_CMD 4'h0
`define PFCR_OFF_STAT 4'h4
`define PFCR_OFF_MASK 4'h8

// Function_command_control field positions.
`define PFCR_CMD_MEM 1
`define PFCR_CMD_BM 2
`define PFCR_CMD_SPC 3
`define PFCR_CMD_MWI 4
`define PFCR_CMD_VGA 5
`define PFCR_CMD_PERR 6
`define PFCR_CMD_WAIT 7
`define PFCR_CMD_SERR 8
`define PFCR_CMD_FB2B 9

// Writable bits of the function_command_control and its reset value.
`define PFCR_CMD_WMASK 16'h0146
`define PFCR_CMD_RST 16'h0000

// Status register event positions.
`define PFCR_ST_PAR 0
`define PFCR_ST_FAT 1
`define PFCR_ST_NF 2
`define PFCR_ST_MDROP 3
`define PFCR_ST_BMBLK 4
`define PFCR_ST_WMASK 8'h1F
`define PFCR_ST_RST 8'h00
`define PFCR_MASK_RST 8'h00

// Cycles from a taken request to waitrequest low.
`define PFCR_ACK_CYC 1

`endif

// [rtl/pfcr_pkg.sv]
// Types shared by the command block modules.
package pfcr_pkg;

	// Bus slave states, Gray coded along idle to answer.
	typedef enum logic [0:0] {
		PFCR_IDLE = 1'b0,
		PFCR_ANS  = 1'b1
	} pfcr_bus_e;

	typedef logic [15:0] pfcr_cmd_t;
	typedef logic [7:0]  pfcr_stat_t;

endpackage : pfcr_pkg

// [rtl/pfcr_gate_if.sv]
// Carrier between the register front end and the request gate.
`timescale 1ns/1ps
interface pfcr_gate_if;
	logic mem_en;
	logic bm_en;
	logic perr_en;
	logic serr_en;
	logic mem_req;
	logic mst_req;
	logic par_err;
	logic fat_err;
	logic nf_err;
	logic mem_grant;
	logic mem_drop;
	logic mst_go;
	logic mst_blk;
	logic par_seen;
	logic par_act;
	logic fat_msg;
	logic nf_msg;

	// Register side drives enables and events, reads the gated pulses.
	modport ctl (
		output mem_en, bm_en, perr_en, serr_en,
		output mem_req, mst_req, par_err, fat_err, nf_err,
		input  mem_grant, mem_drop, mst_go, mst_blk,
		input  par_seen, par_act, fat_msg, nf_msg
	);

	// Gate side.
	modport gate (
		input  mem_en, bm_en, perr_en, serr_en,
		input  mem_req, mst_req, par_err, fat_err, nf_err,
		output mem_grant, mem_drop, mst_go, mst_blk,
		output par_seen, par_act, fat_msg, nf_msg
	);
endinterface : pfcr_gate_if

// [rtl/pfcr_gate.sv]
// Request and error gate steered by the command enables.
`timescale 1ns/1ps
module pfcr_gate
	import pfcr_pkg::*;
(
	input  wire logic i_mclk,
	input  wire logic i_rst,
	pfcr_gate_if.gate g
);

	logic mem_grant, next_mem_grant;
	logic mem_drop,  next_mem_drop;
	logic mst_go,    next_mst_go;
	logic mst_blk,   next_mst_blk;
	logic par_seen,  next_par_seen;
	logic par_act,   next_par_act;
	logic fat_msg,   next_fat_msg;
	logic nf_msg,    next_nf_msg;

	// Every outcome is a registered pulse so the top outputs stay flop driven.
	always_comb begin
		next_mem_grant = g.mem_req & g.mem_en;
		next_mem_drop  = g.mem_req & ~g.mem_en;
		next_mst_go    = g.mst_req & g.bm_en;
		next_mst_blk   = g.mst_req & ~g.bm_en;
		next_par_seen  = g.par_err;
		next_par_act   = g.par_err & g.perr_en;
		next_fat_msg   = g.fat_err & g.serr_en;
		next_nf_msg    = g.nf_err & g.serr_en;
	end

	// Pulses clear on reset so nothing leaks out before software sets enables.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			mem_grant <= 1'b0;
			mem_drop  <= 1'b0;
			mst_go    <= 1'b0;
			mst_blk   <= 1'b0;
			par_seen  <= 1'b0;
			par_act   <= 1'b0;
			fat_msg   <= 1'b0;
			nf_msg    <= 1'b0;
		end else begin
			mem_grant <= next_mem_grant;
			mem_drop  <= next_mem_drop;
			mst_go    <= next_mst_go;
			mst_blk   <= next_mst_blk;
			par_seen  <= next_par_seen;
			par_act   <= next_par_act;
			fat_msg   <= next_fat_msg;
			nf_msg    <= next_nf_msg;
		end
	end

	// Drive the carrier.
	assign g.mem_grant = mem_grant;
	assign g.mem_drop  = mem_drop;
	assign g.mst_go    = mst_go;
	assign g.mst_blk   = mst_blk;
	assign g.par_seen  = par_seen;
	assign g.par_act   = par_act;
	assign g.fat_msg   = fat_msg;
	assign g.nf_msg    = nf_msg;

endmodule : pfcr_gate

// [rtl/pfcr_top.sv]
// Function function_command_control bank with Avalon-MM slave and event interrupt.
//
// Contract
// - Memory requests answered only while memory enable set.
// - Upstream requests only while master enable set.
// - Legacy command bits hardwired zero, read only.
// - Parity response enable writable, resets zero, acts.
// - Detected parity error always sets status flag.
// - Error reporting enable writable, gates error reports.
// - Memory enable writable, cleared out of reset.
`timescale 1ns/1ps
`include "pfcr_cfg.svh"
module pfcr_top
	import pfcr_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic [3:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	output logic             o_irq,
	input  wire logic        i_mem_req,
	output logic             o_mem_grant,
	output logic             o_mem_drop,
	input  wire logic        i_mst_req,
	output logic             o_mst_go,
	input  wire logic        i_parity_err,
	output logic             o_parity_act,
	input  wire logic        i_fatal_err,
	input  wire logic        i_nonfatal_err,
	output logic             o_fatal_msg,
	output logic             o_nonfatal_msg,
	output logic             o_mem_en,
	output logic             o_bm_en
);

	// Keep only the writable command bits; everything else is forced low.
	function automatic pfcr_cmd_t cmd_clean(input pfcr_cmd_t v);
		cmd_clean = v & `PFCR_CMD_WMASK;
	endfunction : cmd_clean

	// Merge one 16-bit field from the bus under its two byte enables.
	function automatic logic [15:0] lane16(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [1:0]  be
	);
		lane16 = {be[1] ? new_v[15:8] : old_v[15:8],
		          be[0] ? new_v[7:0]  : old_v[7:0]};
	endfunction : lane16

	// Bus slave state.
	pfcr_bus_e   state, next_state;
	logic        wait_q, next_wait_q;
	logic [31:0] rdata, next_rdata;

	// Register file state.
	pfcr_cmd_t   cmd, next_cmd;
	pfcr_stat_t  stat, next_stat;
	pfcr_stat_t  mask, next_mask;
	logic        irq, next_irq;

	// Decoded bus terms.
	logic        req;
	logic        done;
	logic        hit_cmd;
	logic        hit_stat;
	logic        hit_mask;
	pfcr_stat_t  stat_set;
	pfcr_stat_t  stat_clr;
	pfcr_cmd_t   cmd_wr;

	// Gate carrier.
	pfcr_gate_if gif ();

	// A request is completed only at the edge where waitrequest is low.
	assign req      = i_read | i_write;
	assign done     = req & ~wait_q;
	assign hit_cmd  = i_address == `PFCR_OFF_CMD;
	assign hit_stat = i_address == `PFCR_OFF_STAT;
	assign hit_mask = i_address == `PFCR_OFF_MASK;

	// Bus handshake: one cycle of waitrequest high, then one cycle low.
	always_comb begin
		next_state  = state;
		next_wait_q = wait_q;
		next_rdata  = rdata;
		case (state)
			PFCR_IDLE: begin
				next_wait_q = 1'b1;
				if (req) begin
					next_state  = PFCR_ANS;
					next_wait_q = 1'b0;
					next_rdata  = 32'h0000_0000;
					if (i_read) begin
						if (hit_cmd) begin
							next_rdata = {16'h0000, cmd_clean(cmd)};
						end else if (hit_stat) begin
							next_rdata = {24'h00_0000, stat};
						end else if (hit_mask) begin
							next_rdata = {24'h00_0000, mask};
						end
					end
				end
			end
			PFCR_ANS: begin
				// The master releases after this edge; go back to waiting.
				next_state  = PFCR_IDLE;
				next_wait_q = 1'b1;
			end
			default: begin
				next_state  = PFCR_IDLE;
				next_wait_q = 1'b1;
				next_rdata  = 32'h0000_0000;
			end
		endcase
	end

	// Bus slave registers; waitrequest stays high through reset.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state  <= PFCR_IDLE;
			wait_q <= 1'b1;
			rdata  <= 32'h0000_0000;
		end else begin
			state  <= next_state;
			wait_q <= next_wait_q;
			rdata  <= next_rdata;
		end
	end

	// Candidate command value; hardwired bits never take the written data.
	assign cmd_wr = cmd_clean(lane16(cmd, i_writedata[15:0], i_byteenable[1:0]));

	// Events raised by the gate one cycle after their cause.
	always_comb begin
		stat_set                 = 8'h00;
		stat_set[`PFCR_ST_PAR]   = gif.par_seen;
		stat_set[`PFCR_ST_FAT]   = gif.fat_msg;
		stat_set[`PFCR_ST_NF]    = gif.nf_msg;
		stat_set[`PFCR_ST_MDROP] = gif.mem_drop;
		stat_set[`PFCR_ST_BMBLK] = gif.mst_blk;
	end

	// A completed read clears only the bits that it returned. An event that lands after
	// the read word was captured stays pending for the next read instead of being lost.
	assign stat_clr = (done & i_read & hit_stat) ? rdata[7:0] : 8'h00;

	// Register file next values.
	always_comb begin
		next_cmd  = cmd;
		next_mask = mask;
		if (done & i_write & hit_cmd) begin
			next_cmd = cmd_wr;
		end
		if (done & i_write & hit_mask & i_byteenable[0]) begin
			next_mask = i_writedata[7:0] & `PFCR_ST_WMASK;
		end
		// An event in the clearing cycle survives because the set is applied last.
		next_stat = ((stat & ~stat_clr) | stat_set) & `PFCR_ST_WMASK;
		next_irq  = |(next_stat & next_mask);
	end

	// Enables come out of reset cleared so the function stays silent.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cmd  <= `PFCR_CMD_RST;
			stat <= `PFCR_ST_RST;
			mask <= `PFCR_MASK_RST;
			irq  <= 1'b0;
		end else begin
			cmd  <= next_cmd;
			stat <= next_stat;
			mask <= next_mask;
			irq  <= next_irq;
		end
	end

	// Enables and function events handed to the gate.
	assign gif.mem_en  = cmd[`PFCR_CMD_MEM];
	assign gif.bm_en   = cmd[`PFCR_CMD_BM];
	assign gif.perr_en = cmd[`PFCR_CMD_PERR];
	assign gif.serr_en = cmd[`PFCR_CMD_SERR];
	assign gif.mem_req = i_mem_req;
	assign gif.mst_req = i_mst_req;
	assign gif.par_err = i_parity_err;
	assign gif.fat_err = i_fatal_err;
	assign gif.nf_err  = i_nonfatal_err;

	// The gate registers every outcome, so the top outputs stay flop driven.
	pfcr_gate u_gate (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.g      (gif.gate)
	);

	// Bus and interrupt outputs.
	assign o_readdata    = rdata;
	assign o_waitrequest = wait_q;
	assign o_irq         = irq;

	// Function-side outputs.
	assign o_mem_grant    = gif.mem_grant;
	assign o_mem_drop     = gif.mem_drop;
	assign o_mst_go       = gif.mst_go;
	assign o_parity_act   = gif.par_act;
	assign o_fatal_msg    = gif.fat_msg;
	assign o_nonfatal_msg = gif.nf_msg;

	// Enable levels for the request logic, straight from the command flops.
	assign o_mem_en = cmd[`PFCR_CMD_MEM];
	assign o_bm_en  = cmd[`PFCR_CMD_BM];

endmodule : pfcr_top

// [testbench/pfcr_top_props.sv]
// Timing checks on the command block ports.
`timescale 1ns/1ps
`include "pfcr_cfg.svh"
module pfcr_props (
	input wire logic        i_mclk,
	input wire logic        i_rst,
	input wire logic [3:0]  i_address,
	input wire logic        i_read,
	input wire logic        i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0]  i_byteenable,
	input wire logic [31:0] o_readdata,
	input wire logic        o_waitrequest,
	input wire logic        o_irq,
	input wire logic        i_mem_req,
	input wire logic        o_mem_grant,
	input wire logic        o_mem_drop,
	input wire logic        i_mst_req,
	input wire logic        o_mst_go,
	input wire logic        i_parity_err,
	input wire logic        o_parity_act,
	input wire logic        i_fatal_err,
	input wire logic        o_fatal_msg,
	input wire logic        i_nonfatal_err,
	input wire logic        o_nonfatal_msg,
	input wire logic        o_mem_en,
	input wire logic        o_bm_en
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// A request first seen, a command write being taken and a command read answered.
	sequence s_req; (i_read || i_write) && o_waitrequest; endsequence
	sequence s_wcmd;
		i_write && !o_waitrequest && i_address == `PFCR_OFF_CMD && i_byteenable[0];
	endsequence
	sequence s_rcmd; i_read && !o_waitrequest && i_address == `PFCR_OFF_CMD; endsequence
	AST_BUS_ACK: assert property (s_req |=> !o_waitrequest)
		else $error("Bus answer late.");
	AST_BUS_ONE: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("Bus answer held too long.");
	AST_HARDWIRED: assert property (s_rcmd |->
		(o_readdata & ~{16'h0000, `PFCR_CMD_WMASK}) == 32'h0)
		else $error("Hardwired bit read as one.");
	AST_EN_WRITE: assert property (s_wcmd |=> o_mem_en == $past(i_writedata[1]) &&
		o_bm_en == $past(i_writedata[2])) else $error("Enable did not follow write.");
	AST_MEM_GRANT: assert property (i_mem_req && o_mem_en |=> o_mem_grant && !o_mem_drop)
		else $error("Memory request not granted.");
	AST_MEM_DROP: assert property (i_mem_req && !o_mem_en |=> o_mem_drop && !o_mem_grant)
		else $error("Memory request answered while disabled.");
	AST_MST_GO: assert property (i_mst_req && o_bm_en |=> o_mst_go)
		else $error("Master request lost.");
	AST_MST_BLK: assert property (i_mst_req && !o_bm_en |=> !o_mst_go)
		else $error("Master request passed while disabled.");
	AST_PAR_SRC: assert property (o_parity_act |-> $past(i_parity_err))
		else $error("Parity action without error.");
	AST_FAT_SRC: assert property (o_fatal_msg |-> $past(i_fatal_err))
		else $error("Fatal report without error.");
	AST_NF_SRC: assert property (o_nonfatal_msg |-> $past(i_nonfatal_err))
		else $error("Non-fatal report without error.");
	AST_RST_EN: assert property ($fell(i_rst) |-> !o_mem_en && !o_bm_en)
		else $error("Enable set out of reset.");
	AST_RST_IRQ: assert property ($fell(i_rst) |-> !o_irq)
		else $error("Interrupt set out of reset.");
endmodule : pfcr_props

// [testbench/pfcr_func_model.sv]
// Function-side source of requests and error events.
`timescale 1ns/1ps
module pfcr_func_model (
	input wire logic       i_mclk,
	input wire logic       i_fire,
	input wire logic [4:0] i_pat,
	output logic     [4:0] o_ev = 5'h00
);
	// One cycle of events per fire, so that each pulse counts exactly once.
	always @(posedge i_mclk) begin
		o_ev <= i_fire ? i_pat : 5'h00;
	end
endmodule : pfcr_func_model

// [testbench/pcie_function_function_command_control_test.sv]
// Self-checking bench of the command block.
`timescale 1ns/1ps
`include "pfcr_cfg.svh"
module pcie_function_function_command_control_test;
	logic        i_mclk = 1'b0, i_rst = 1'b1, i_read = 1'b0, i_write = 1'b0, fire = 1'b0;
	logic [3:0]  i_address = 4'h0, i_byteenable = 4'hF;
	logic [31:0] i_writedata = 32'h0, o_readdata;
	logic [4:0]  pat = 5'h00, ev;
	logic        o_waitrequest, o_irq, o_mem_grant, o_mem_drop, o_mst_go, o_parity_act;
	logic        o_fatal_msg, o_nonfatal_msg, o_mem_en, o_bm_en;
	logic [31:0] q[$];
	logic [15:0] cmdv = 16'h0146, m;
	logic [7:0]  lf = 8'h3B;
	int          mismatches = 0, tests_run = 0, cyc = 0;
	// Clock and a cycle ceiling that cuts a hang short.
	always #4 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			report_and_stop();
		end
	end
	pfcr_func_model u_fn (.i_mclk(i_mclk), .i_fire(fire), .i_pat(pat), .o_ev(ev));
	pfcr_top dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
		.i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_irq(o_irq),
		.i_mem_req(ev[3]), .o_mem_grant(o_mem_grant), .o_mem_drop(o_mem_drop),
		.i_mst_req(ev[4]), .o_mst_go(o_mst_go), .i_parity_err(ev[0]),
		.o_parity_act(o_parity_act), .i_fatal_err(ev[1]), .i_nonfatal_err(ev[2]),
		.o_fatal_msg(o_fatal_msg), .o_nonfatal_msg(o_nonfatal_msg), .o_mem_en(o_mem_en),
		.o_bm_en(o_bm_en));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, s);
			mismatches++;
		end
	endtask : chk
	// One access; a read notes its expected word for the monitor.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge i_mclk);
		i_write <= wr;
		i_read <= !wr;
		i_address <= a;
		i_writedata <= d;
		i_byteenable <= be;
		if (!wr) q.push_back(d);
		do @(posedge i_mclk); while (o_waitrequest !== 1'b0);
		i_write <= 1'b0;
		i_read <= 1'b0;
	endtask : bus
	// One fire of the function model; the registered answers stand two cycles after it.
	task automatic pulse(input logic [4:0] p, input logic [5:0] e);
		logic [5:0] s;
		@(posedge i_mclk);
		fire <= 1'b1;
		pat <= p;
		@(posedge i_mclk);
		fire <= 1'b0;
		@(posedge i_mclk);
		@(negedge i_mclk);
		s = {o_mst_go, o_mem_drop, o_mem_grant, o_nonfatal_msg, o_fatal_msg, o_parity_act};
		chk("gate outputs", {26'h0, e}, {26'h0, s});
		repeat (3) @(posedge i_mclk);
	endtask : pulse
	task report_and_stop;
		$display("Counts: %0d compared, %0d mismatched", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	// Read data are compared with the oldest note when the answer stands.
	always @(posedge i_mclk) begin
		if (i_read && !o_waitrequest) chk("readdata", q.pop_front(), o_readdata);
	end
	// Main sequence.
	initial begin
		repeat (4) @(posedge i_mclk);
		i_rst <= 1'b0;
		bus(0, `PFCR_OFF_CMD, 32'h0, 4'hF);
		bus(0, `PFCR_OFF_STAT, 32'h0, 4'hF);
		bus(0, `PFCR_OFF_MASK, 32'h0, 4'hF);
		$display("Reset values done.");
		bus(1, `PFCR_OFF_CMD, 32'hFFFF_FFFF, 4'hF);
		bus(0, `PFCR_OFF_CMD, 32'h0146, 4'hF);
		@(negedge i_mclk);
		chk("mem_en", 32'h1, {31'h0, o_mem_en});
		chk("bm_en", 32'h1, {31'h0, o_bm_en});
		for (int k = 0; k < 8; k++) begin
			lf = lfsr(lf);
			m = {{8{lf[1]}}, {8{lf[0]}}};
			cmdv = ((cmdv & ~m) | ({lf, lf} & m)) & `PFCR_CMD_WMASK;
			bus(1, `PFCR_OFF_CMD, {4{lf}}, lf[3:0]);
			bus(0, `PFCR_OFF_CMD, {16'h0, cmdv}, 4'hF);
		end
		$display("Command writes done.");
		@(posedge i_mclk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		bus(0, `PFCR_OFF_CMD, 32'h0, 4'hF);
		bus(1, `PFCR_OFF_CMD, 32'h0146, 4'hF);
		pulse(5'h1F, 6'h2F);
		@(negedge i_mclk);
		chk("irq masked", 32'h0, {31'h0, o_irq});
		bus(0, `PFCR_OFF_STAT, 32'h07, 4'hF);
		bus(0, `PFCR_OFF_STAT, 32'h0, 4'hF);
		bus(1, `PFCR_OFF_CMD, 32'h0, 4'hF);
		bus(1, `PFCR_OFF_MASK, 32'h08, 4'hF);
		pulse(5'h1F, 6'h10);
		@(negedge i_mclk);
		chk("irq", 32'h1, {31'h0, o_irq});
		bus(0, `PFCR_OFF_STAT, 32'h19, 4'hF);
		repeat (2) @(negedge i_mclk);
		chk("irq cleared", 32'h0, {31'h0, o_irq});
		// A dropped memory request lands in status just after the read word is captured.
		fork
			pulse(5'h08, 6'h10);
			begin
				repeat (2) @(posedge i_mclk);
				bus(0, `PFCR_OFF_STAT, 32'h0, 4'hF);
			end
		join
		bus(0, `PFCR_OFF_STAT, 32'h08, 4'hF);
		$display("Events done.");
		bus(1, `PFCR_OFF_STAT, 32'hFF, 4'hF);
		bus(0, `PFCR_OFF_STAT, 32'h0, 4'hF);
		bus(1, 4'hC, 32'hFFFF_FFFF, 4'hF);
		bus(0, 4'hC, 32'h0, 4'hF);
		bus(0, `PFCR_OFF_MASK, 32'h08, 4'hF);
		$display("Unmapped access done.");
		report_and_stop();
	end
endmodule : pcie_function_function_command_control_test
bind pfcr_top pfcr_props u_props (.i_mclk, .i_rst, .i_address, .i_read, .i_write,
	.i_writedata, .i_byteenable, .o_readdata, .o_waitrequest, .i_mem_req, .o_mem_grant,
	.o_mem_drop, .i_mst_req, .o_mst_go, .i_parity_err, .o_parity_act, .i_fatal_err,
	.o_fatal_msg, .o_mem_en, .o_bm_en, .o_irq, .i_nonfatal_err, .o_nonfatal_msg);
